// ==== verilog/nni_device_end.sv ====
// Our own choices: the placing of the registers and the address-and-strobe port.
`default_nettype none
module nni_device_end #(
  parameter int NUM_PVC = 16,
  parameter int MON_EVT = nni_pkg::MON_EVT_DEF,
  parameter int ERR_THR = nni_pkg::ERR_THR_DEF
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  nni_link_if.dev link,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic nni_poll_ok_in,
  input wire logic nni_poll_err_in,
  input wire logic uni_poll_ok_in,
  input wire logic uni_poll_err_in,
  input wire logic svc_pending_in,
  output logic [NUM_PVC-1:0] user_present_out,
  output logic [NUM_PVC-1:0] user_active_out,
  output logic user_new_out,
  output logic [$clog2(NUM_PVC)-1:0] user_new_idx_out
);
  import nni_pkg::*;
  localparam int IDX_W = $clog2(NUM_PVC);
  logic len4, dc, pvc_hit, any_pend, grant, frm_ok, rx_hit;
  logic [1:0] chan_active, poll_ok, poll_err;
  logic [NUM_PVC-1:0] cfg, seg_ok, rem_act, rem_pres, sent_act, del_pend, new_reply;
  logic [NUM_PVC-1:0] add_pend, local_act, pend;
  logic [DLCI_W-1:0] tx_dlci, frm_dlci, pvc_dlci [NUM_PVC];
  logic [7:0] pvc_off, tx_stat, frm_stat;
  logic [IDX_W-1:0] reg_idx, sel, rx_idx;
  tx_state_t state;
  logic [2:0] txi, alen;
  logic [15:0] tmr;
  assign poll_ok = {uni_poll_ok_in, nni_poll_ok_in};
  assign poll_err = {uni_poll_err_in, nni_poll_err_in};
  assign alen = len4 ? 3'(ADDR_LEN4) : 3'(ADDR_LEN2);
  assign pvc_off = reg_addr_in - REG_PVC_BASE;
  assign pvc_hit = (reg_addr_in >= REG_PVC_BASE) && (pvc_off[7:2] < 6'(NUM_PVC)) &&
                   (pvc_off[1:0] == 2'h0);
  assign reg_idx = pvc_off[IDX_W+1:2];
  // Link integrity monitor for the network-side and user-side channels
  for (genvar c = 0; c < 2; c++) begin : g_mon
    logic act;
    logic [7:0] ev_cnt, err_cnt, ok_cnt;
    assign chan_active[c] = act;
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        act <= 1'b0;
        ev_cnt <= 8'h00;
        err_cnt <= 8'h00;
        ok_cnt <= 8'h00;
      end else if (act) begin
        if (poll_err[c] && (err_cnt + 8'h01 >= 8'(ERR_THR))) begin
          act <= 1'b0;
          ev_cnt <= 8'h00;
          err_cnt <= 8'h00;
          ok_cnt <= 8'h00;
        end else if (poll_ok[c] || poll_err[c]) begin
          if (ev_cnt + 8'h01 >= 8'(MON_EVT)) begin
            ev_cnt <= 8'h00;
            err_cnt <= 8'h00;
          end else begin
            ev_cnt <= ev_cnt + 8'h01;
            err_cnt <= err_cnt + {7'h00, poll_err[c]};
          end
        end
      end else if (poll_err[c]) begin
        ok_cnt <= 8'h00;
      end else if (poll_ok[c]) begin
        if (ok_cnt + 8'h01 >= 8'(MON_EVT)) begin
          act <= 1'b1;
          ok_cnt <= 8'h00;
        end else begin
          ok_cnt <= ok_cnt + 8'h01;
        end
      end
    end
  end
  always_comb begin
    any_pend = 1'b0;
    sel = '0;
    for (int i = 0; i < NUM_PVC; i++) begin
      // Reported state depends only on local conditions
      local_act[i] = cfg[i] & seg_ok[i] & chan_active[CH_UNI];
      pend[i] = (cfg[i] & ((local_act[i] != sent_act[i]) | new_reply[i] | add_pend[i])) |
                del_pend[i];
      if (pend[i] && !any_pend) begin
        any_pend = 1'b1;
        sel = IDX_W'(i);
      end
    end
  end
  always_comb begin
    rx_hit = 1'b0;
    rx_idx = '0;
    for (int i = 0; i < NUM_PVC; i++) begin
      if (cfg[i] && pvc_dlci[i] == frm_dlci && !rx_hit) begin
        rx_hit = 1'b1;
        rx_idx = IDX_W'(i);
      end
    end
  end
  assign grant = (state == TX_IDLE) && any_pend && !svc_pending_in;
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      len4 <= 1'b1;
      dc <= 1'b0;
      cfg <= '0;
      seg_ok <= '0;
      for (int i = 0; i < NUM_PVC; i++) begin
        pvc_dlci[i] <= '0;
      end
    end else if (reg_wr_in) begin
      if (reg_addr_in == REG_CTRL) begin
        len4 <= reg_wdata_in[CTRL_LEN4];
        dc <= reg_wdata_in[CTRL_DC];
      end else if (pvc_hit) begin
        cfg[reg_idx] <= reg_wdata_in[PVC_CFG];
        seg_ok[reg_idx] <= reg_wdata_in[PVC_SEG_OK];
        if (reg_wdata_in[PVC_CFG]) begin
          pvc_dlci[reg_idx] <= reg_wdata_in[DLCI_W-1:0];
        end
      end
    end
  end
  // Report bookkeeping: a set in the same cycle as the grant wins
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sent_act <= '0;
      del_pend <= '0;
      new_reply <= '0;
      add_pend <= '0;
    end else begin
      if (grant) begin
        sent_act[sel] <= local_act[sel] & ~del_pend[sel];
        del_pend[sel] <= 1'b0;
        new_reply[sel] <= 1'b0;
        add_pend[sel] <= 1'b0;
      end
      if (reg_wr_in && pvc_hit) begin
        if (cfg[reg_idx] && !reg_wdata_in[PVC_CFG]) begin
          del_pend[reg_idx] <= 1'b1;
        end else if (!cfg[reg_idx] && reg_wdata_in[PVC_CFG]) begin
          add_pend[reg_idx] <= 1'b1;
        end
      end
      if (frm_ok && rx_hit && frm_stat[ST_NEW_POS]) begin
        new_reply[rx_idx] <= 1'b1;
      end
    end
  end
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= TX_IDLE;
      txi <= 3'h0;
      tmr <= 16'h0000;
      tx_dlci <= '0;
      tx_stat <= 8'h00;
      link.dev_valid <= 1'b0;
      link.dev_data <= 8'h00;
      link.dev_last <= 1'b0;
    end else begin
      case (state)
        TX_IDLE: begin
          link.dev_valid <= 1'b0;
          link.dev_last <= 1'b0;
          if (grant) begin
            tx_dlci <= pvc_dlci[sel];
            tx_stat <= status_octet(add_pend[sel], del_pend[sel],
                                    local_act[sel] & ~del_pend[sel]);
            txi <= 3'h0;
            state <= TX_SEND;
          end
        end
        TX_SEND: begin
          link.dev_valid <= 1'b1;
          link.dev_last <= (txi == alen);
          link.dev_data <= (txi == alen) ? tx_stat : addr_octet(txi, len4, dc, tx_dlci);
          if (txi == alen) begin
            tmr <= 16'h0000;
            state <= TX_WAIT;
          end else begin
            txi <= txi + 3'h1;
          end
        end
        TX_WAIT: begin
          link.dev_valid <= 1'b0;
          link.dev_last <= 1'b0;
          if (link.peer_ack) begin
            state <= TX_IDLE;
          end else if (tmr == 16'(RETX_CYC - 1)) begin
            txi <= 3'h0;
            state <= TX_SEND;
          end else begin
            tmr <= tmr + 16'h0001;
          end
        end
        default: state <= TX_IDLE;
      endcase
    end
  end
  frame_addr_check u_check (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .len4_in(len4),
    .valid_in(link.peer_valid),
    .data_in(link.peer_data),
    .last_in(link.peer_last),
    .ok_out(frm_ok),
    .bad_out(),
    .dlci_out(frm_dlci),
    .stat_out(frm_stat)
  );
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rem_act <= '0;
      rem_pres <= '0;
      link.dev_ack <= 1'b0;
      user_new_out <= 1'b0;
      user_new_idx_out <= '0;
    end else begin
      link.dev_ack <= frm_ok;
      user_new_out <= 1'b0;
      if (frm_ok && rx_hit) begin
        rem_act[rx_idx] <= frm_stat[ST_ACT_POS];
        rem_pres[rx_idx] <= ~frm_stat[ST_DEL_POS];
        if (frm_stat[ST_NEW_POS]) begin
          user_new_out <= 1'b1;
          user_new_idx_out <= rx_idx;
        end
      end
    end
  end
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      user_present_out <= '0;
      user_active_out <= '0;
    end else begin
      user_present_out <= cfg;
      user_active_out <= cfg & seg_ok & rem_pres & rem_act &
                         {NUM_PVC{chan_active[CH_NNI]}};
    end
  end
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 32'h00000000;
    end else begin
      reg_rdata_out <= 32'h00000000;
      if (reg_rd_in) begin
        if (reg_addr_in == REG_CTRL) begin
          reg_rdata_out[CTRL_LEN4] <= len4;
          reg_rdata_out[CTRL_DC] <= dc;
        end else if (reg_addr_in == REG_STATUS) begin
          reg_rdata_out[STAT_NNI_ACT] <= chan_active[CH_NNI];
          reg_rdata_out[STAT_UNI_ACT] <= chan_active[CH_UNI];
          reg_rdata_out[STAT_TX_BUSY] <= (state != TX_IDLE);
        end else if (pvc_hit) begin
          reg_rdata_out[DLCI_W-1:0] <= pvc_dlci[reg_idx];
          reg_rdata_out[PVC_CFG] <= cfg[reg_idx];
          reg_rdata_out[PVC_SEG_OK] <= seg_ok[reg_idx];
          reg_rdata_out[PVC_REM_ACT] <= rem_act[reg_idx];
          reg_rdata_out[PVC_REM_PRES] <= rem_pres[reg_idx];
          reg_rdata_out[PVC_USER_ACT] <= user_active_out[reg_idx];
          reg_rdata_out[PVC_SENT_ACT] <= sent_act[reg_idx];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== verilog/nni_pkg.sv ====
// Overview of operation
// - One address length per interface, never mixed
// - Four octets: EA zero, zero, zero, one
// - Two octets: EA zero then one
// - Three-octet address is never valid
// - Four octets, select one: 17-bit identifier
// - Four octets, select zero: 23-bit identifier
// - Two octets: 10-bit identifier
// - Send only changed connection status, on change
// - Link layer retransmits until acknowledged
// - User channel failure reports connection inactive
// - Sent active bit ignores received active bit
// - Segment failure inactive, restoration active
// - Network channel down: all user connections inactive
// - Network channel up after monitored good polls
// - Remote absent: local present but inactive
// - Locally deleted connection reported absent
// - Signalling messages take priority over status
// - Received new indication forwarded onward for configured connections only
// - Answer new indication with current status
`default_nettype none
package nni_pkg;
  localparam int DLCI_W = 23;
  localparam int ADDR_LEN2 = 2;
  localparam int ADDR_LEN4 = 4;
  localparam int EA_POS = 0;
  localparam int DC_POS = 1;
  localparam int ST_NEW_POS = 3;
  localparam int ST_DEL_POS = 2;
  localparam int ST_ACT_POS = 1;
  // monitored_event_count and error_threshold_count defaults
  localparam int MON_EVT_DEF = 4;
  localparam int ERR_THR_DEF = 3;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RETX_TIME_NS = 2000;
  localparam int RETX_CYC = (RETX_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PVC_BASE = 8'h40;
  localparam int CTRL_LEN4 = 0;
  localparam int CTRL_DC = 1;
  localparam int PVC_CFG = 24;
  localparam int PVC_SEG_OK = 25;
  localparam int PVC_REM_ACT = 26;
  localparam int PVC_REM_PRES = 27;
  localparam int PVC_USER_ACT = 28;
  localparam int PVC_SENT_ACT = 29;
  localparam int STAT_NNI_ACT = 0;
  localparam int STAT_UNI_ACT = 1;
  localparam int STAT_TX_BUSY = 2;
  localparam int CH_NNI = 0;
  localparam int CH_UNI = 1;

  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_WAIT} tx_state_t;

  function automatic logic [7:0] addr_octet(input logic [2:0] idx, input logic len4,
                                            input logic dc, input logic [DLCI_W-1:0] d);
    logic [7:0] o;
    o = 8'h00;
    if (!len4) begin
      case (idx)
        3'h0: o = {d[9:4], 2'h0};
        default: o = {d[3:0], 4'h1};
      endcase
    end else if (dc) begin
      case (idx)
        3'h0: o = {d[16:11], 2'h0};
        3'h1: o = {d[10:7], 4'h0};
        3'h2: o = {d[6:0], 1'h0};
        default: o = 8'h03;
      endcase
    end else begin
      case (idx)
        3'h0: o = {d[22:17], 2'h0};
        3'h1: o = {d[16:13], 4'h0};
        3'h2: o = {d[12:6], 1'h0};
        default: o = {d[5:0], 2'h1};
      endcase
    end
    return o;
  endfunction

  function automatic logic [7:0] status_octet(input logic nw, input logic del, input logic act);
    logic [7:0] o;
    o = 8'h00;
    o[ST_NEW_POS] = nw;
    o[ST_DEL_POS] = del;
    o[ST_ACT_POS] = act;
    return o;
  endfunction
endpackage
`default_nettype wire

// ==== verilog/nni_link_if.sv ====
`default_nettype none
interface nni_link_if;
  logic dev_valid;
  logic [7:0] dev_data;
  logic dev_last;
  logic dev_ack;
  logic peer_valid;
  logic [7:0] peer_data;
  logic peer_last;
  logic peer_ack;
  modport dev (output dev_valid, dev_data, dev_last, dev_ack,
               input peer_valid, peer_data, peer_last, peer_ack);
  modport peer (input dev_valid, dev_data, dev_last, dev_ack,
                output peer_valid, peer_data, peer_last, peer_ack);
endinterface
`default_nettype wire

// ==== verilog/frame_addr_check.sv ====
`default_nettype none
module frame_addr_check (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic len4_in,
  input wire logic valid_in,
  input wire logic [7:0] data_in,
  input wire logic last_in,
  output logic ok_out,
  output logic bad_out,
  output logic [nni_pkg::DLCI_W-1:0] dlci_out,
  output logic [7:0] stat_out
);
  import nni_pkg::*;
  logic [2:0] idx;
  logic bad;
  logic [DLCI_W-1:0] acc;
  logic [2:0] alen;
  logic [DLCI_W-1:0] next_acc;
  logic next_bad;

  assign alen = len4_in ? 3'(ADDR_LEN4) : 3'(ADDR_LEN2);

  always_comb begin
    next_acc = acc;
    next_bad = bad;
    if (idx < alen) begin
      // Extension bit must be set on the last address octet only
      if (data_in[EA_POS] != (idx == alen - 3'h1)) begin
        next_bad = 1'b1;
      end
      case (idx)
        3'h0: next_acc = DLCI_W'(data_in[7:2]);
        3'h1: next_acc = {acc[DLCI_W-5:0], data_in[7:4]};
        3'h2: next_acc = {acc[DLCI_W-8:0], data_in[7:1]};
        default: begin
          if (!data_in[DC_POS]) begin
            next_acc = {acc[DLCI_W-7:0], data_in[7:2]};
          end
        end
      endcase
    end else if (idx > alen) begin
      next_bad = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      idx <= 3'h0;
      bad <= 1'b0;
      acc <= '0;
      ok_out <= 1'b0;
      bad_out <= 1'b0;
      dlci_out <= '0;
      stat_out <= 8'h00;
    end else begin
      ok_out <= 1'b0;
      bad_out <= 1'b0;
      if (valid_in) begin
        if (last_in) begin
          idx <= 3'h0;
          bad <= 1'b0;
          acc <= '0;
          if (next_bad || idx != alen) begin
            bad_out <= 1'b1;
          end else begin
            ok_out <= 1'b1;
            dlci_out <= acc;
            stat_out <= data_in;
          end
        end else begin
          if (idx != 3'h7) begin
            idx <= idx + 3'h1;
          end
          bad <= next_bad;
          acc <= next_acc;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== verilog/nni_peer_end.sv ====
`default_nettype none
module nni_peer_end (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  nni_link_if.peer link,
  input wire logic cfg_len4_in,
  input wire logic cfg_dc_in,
  input wire logic cmd_valid_in,
  input wire logic [nni_pkg::DLCI_W-1:0] cmd_dlci_in,
  input wire logic [2:0] cmd_stat_in,
  output logic cmd_ready_out,
  output logic rx_valid_out,
  output logic [nni_pkg::DLCI_W-1:0] rx_dlci_out,
  output logic [2:0] rx_stat_out
);
  import nni_pkg::*;
  tx_state_t state;
  logic [2:0] txi;
  logic [2:0] alen;
  logic [15:0] tmr;
  logic [DLCI_W-1:0] tx_dlci;
  logic [7:0] tx_stat;
  logic frm_ok;
  logic [DLCI_W-1:0] frm_dlci;
  logic [7:0] frm_stat;

  assign alen = cfg_len4_in ? 3'(ADDR_LEN4) : 3'(ADDR_LEN2);

  frame_addr_check u_check (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .len4_in(cfg_len4_in),
    .valid_in(link.dev_valid),
    .data_in(link.dev_data),
    .last_in(link.dev_last),
    .ok_out(frm_ok),
    .bad_out(),
    .dlci_out(frm_dlci),
    .stat_out(frm_stat)
  );

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= TX_IDLE;
      txi <= 3'h0;
      tmr <= 16'h0000;
      tx_dlci <= '0;
      tx_stat <= 8'h00;
      cmd_ready_out <= 1'b1;
      link.peer_valid <= 1'b0;
      link.peer_data <= 8'h00;
      link.peer_last <= 1'b0;
    end else begin
      case (state)
        TX_IDLE: begin
          link.peer_valid <= 1'b0;
          link.peer_last <= 1'b0;
          if (cmd_valid_in && cmd_ready_out) begin
            tx_dlci <= cmd_dlci_in;
            tx_stat <= status_octet(cmd_stat_in[2], cmd_stat_in[1], cmd_stat_in[0]);
            cmd_ready_out <= 1'b0;
            txi <= 3'h0;
            state <= TX_SEND;
          end
        end
        TX_SEND: begin
          link.peer_valid <= 1'b1;
          link.peer_last <= (txi == alen);
          link.peer_data <= (txi == alen) ? tx_stat
                                          : addr_octet(txi, cfg_len4_in, cfg_dc_in, tx_dlci);
          if (txi == alen) begin
            tmr <= 16'h0000;
            state <= TX_WAIT;
          end else begin
            txi <= txi + 3'h1;
          end
        end
        TX_WAIT: begin
          link.peer_valid <= 1'b0;
          link.peer_last <= 1'b0;
          if (link.dev_ack) begin
            cmd_ready_out <= 1'b1;
            state <= TX_IDLE;
          end else if (tmr == 16'(RETX_CYC - 1)) begin
            txi <= 3'h0;
            state <= TX_SEND;
          end else begin
            tmr <= tmr + 16'h0001;
          end
        end
        default: state <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      link.peer_ack <= 1'b0;
      rx_valid_out <= 1'b0;
      rx_dlci_out <= '0;
      rx_stat_out <= 3'h0;
    end else begin
      link.peer_ack <= frm_ok;
      rx_valid_out <= frm_ok;
      if (frm_ok) begin
        rx_dlci_out <= frm_dlci;
        rx_stat_out <= {frm_stat[ST_NEW_POS], frm_stat[ST_DEL_POS], frm_stat[ST_ACT_POS]};
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/nni_link_monitor.sv ====
`default_nettype none
module nni_link_monitor (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic dev_valid,
  input wire logic [7:0] dev_data,
  input wire logic dev_last,
  input wire logic dev_ack,
  input wire logic peer_valid,
  input wire logic [7:0] peer_data,
  input wire logic peer_last,
  input wire logic peer_ack
);
  import nni_pkg::*;
  logic [2:0] dev_cnt;
  logic [2:0] peer_cnt;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);
  // Octet position within the frame in flight, per direction
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) dev_cnt <= 3'h0;
    else if (dev_valid) dev_cnt <= dev_last ? 3'h0 : dev_cnt + 3'h1;
  end
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) peer_cnt <= 3'h0;
    else if (peer_valid) peer_cnt <= peer_last ? 3'h0 : peer_cnt + 3'h1;
  end
  sequence s_dev_mid;
    (dev_valid && !dev_last) ##1 (dev_valid && !dev_last);
  endsequence
  sequence s_dev_end;
    dev_valid && dev_last;
  endsequence
  property p_dev_acked;
    s_dev_end |-> ##2 peer_ack;
  endproperty
  property p_peer_acked;
    peer_valid && peer_last |-> ##2 dev_ack;
  endproperty
  property p_ack_cause;
    dev_ack |-> $past(peer_valid && peer_last, 2);
  endproperty
  property p_dev_len;
    s_dev_end |-> (dev_cnt == 3'h2 || dev_cnt == 3'h4);
  endproperty
  property p_peer_len;
    peer_valid && peer_last |-> (peer_cnt == 3'h2 || peer_cnt == 3'h4);
  endproperty
  property p_dev_ea_first;
    dev_valid && dev_cnt == 3'h0 |-> !dev_data[EA_POS];
  endproperty
  property p_peer_ea_first;
    peer_valid && peer_cnt == 3'h0 |-> !peer_data[EA_POS];
  endproperty
  property p_dev_ea_mid;
    s_dev_mid |-> !$past(dev_data[EA_POS]);
  endproperty
  property p_dev_ea_last;
    s_dev_end |-> $past(dev_data[EA_POS]);
  endproperty
  property p_dev_gap;
    s_dev_end |=> !dev_valid [*2];
  endproperty
  property p_dev_stream;
    dev_valid && !dev_last |=> dev_valid;
  endproperty
  a_dev_acked: assert property (p_dev_acked)
    else $error("device frame not acknowledged");
  a_peer_acked: assert property (p_peer_acked)
    else $error("peer frame not acknowledged");
  a_ack_cause: assert property (p_ack_cause)
    else $error("acknowledge without a received frame");
  a_dev_len: assert property (p_dev_len)
    else $error("device frame length wrong");
  a_peer_len: assert property (p_peer_len)
    else $error("peer frame length wrong");
  a_dev_ea_first: assert property (p_dev_ea_first)
    else $error("device first address octet ends address");
  a_peer_ea_first: assert property (p_peer_ea_first)
    else $error("peer first address octet ends address");
  a_dev_ea_mid: assert property (p_dev_ea_mid)
    else $error("device inner address octet ends address");
  a_dev_ea_last: assert property (p_dev_ea_last)
    else $error("device last address octet does not end address");
  a_dev_gap: assert property (p_dev_gap)
    else $error("device frame started before acknowledge");
  a_dev_stream: assert property (p_dev_stream)
    else $error("device frame octets not contiguous");
endmodule
`default_nettype wire

// ==== test/nni_pvc_address_status_bench.sv ====
`default_nettype none
module nni_pvc_address_status_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import nni_pkg::*;
  localparam int MON = 4;
  localparam int ERR = 3;
  logic core_clk_in = 1'h0;
  logic rstn_in = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [31:0] reg_rdata;
  logic [3:0] poll = 4'h0;
  logic svc = 1'h0;
  logic len4 = 1'h1;
  logic dc = 1'h0;
  logic cmd_valid = 1'h0;
  logic [22:0] cmd_dlci = 23'h0;
  logic [2:0] cmd_stat = 3'h0;
  logic cmd_ready, rx_valid, user_new;
  logic [22:0] rx_dlci, d;
  logic [2:0] rx_stat;
  logic [15:0] pres, act;
  logic [3:0] new_idx;
  int err_count = 0;
  int checks = 0;
  int seed = 32'h0FDD;
  int f, news;
  always #5 core_clk_in = ~core_clk_in;
  nni_link_if nni_link_if_i ();
  nni_device_end #(.NUM_PVC(16), .MON_EVT(MON), .ERR_THR(ERR)) nni_device_end_i (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .link(nni_link_if_i.dev),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .nni_poll_ok_in(poll[0]), .nni_poll_err_in(poll[1]),
    .uni_poll_ok_in(poll[2]), .uni_poll_err_in(poll[3]), .svc_pending_in(svc),
    .user_present_out(pres), .user_active_out(act), .user_new_out(user_new),
    .user_new_idx_out(new_idx));
  nni_peer_end nni_peer_end_i (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .link(nni_link_if_i.peer),
    .cfg_len4_in(len4), .cfg_dc_in(dc), .cmd_valid_in(cmd_valid), .cmd_dlci_in(cmd_dlci),
    .cmd_stat_in(cmd_stat), .cmd_ready_out(cmd_ready), .rx_valid_out(rx_valid),
    .rx_dlci_out(rx_dlci), .rx_stat_out(rx_stat));
  nni_link_monitor nni_link_monitor_i (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .dev_valid(nni_link_if_i.dev_valid), .dev_data(nni_link_if_i.dev_data),
    .dev_last(nni_link_if_i.dev_last), .dev_ack(nni_link_if_i.dev_ack),
    .peer_valid(nni_link_if_i.peer_valid), .peer_data(nni_link_if_i.peer_data),
    .peer_last(nni_link_if_i.peer_last), .peer_ack(nni_link_if_i.peer_ack));
  function automatic logic [22:0] msk(input int w);
    return 23'((64'h1 << w) - 64'h1);
  endfunction
  function automatic logic [31:0] word(input logic c, input logic s, input logic [22:0] v);
    return {6'h00, s, c, 1'h0, v};
  endfunction
  function automatic logic [7:0] pvc(input int n);
    return REG_PVC_BASE + 8'(4 * n);
  endfunction
  task automatic finish_test();
    if (err_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  task automatic fail(input string n);
    $display("mismatch %s expected event seen timeout", n);
    err_count++;
    finish_test();
  endtask
  task automatic tick();
    @(posedge core_clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_in);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge core_clk_in);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge core_clk_in);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge core_clk_in);
    reg_rd <= 1'h0;
    #1;
    chk(n, e, reg_rdata);
  endtask
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge core_clk_in);
      poll[k] <= 1'h1;
      @(posedge core_clk_in);
      poll[k] <= 1'h0;
    end
  endtask
  task automatic send(input logic [22:0] v, input logic [2:0] s);
    int j;
    for (j = 0; j < 400 && cmd_ready !== 1'h1; j++) tick();
    if (j == 400) fail("cmd_ready");
    @(posedge core_clk_in);
    cmd_valid <= 1'h1;
    cmd_dlci <= v;
    cmd_stat <= s;
    @(posedge core_clk_in);
    cmd_valid <= 1'h0;
    repeat (10) tick();
  endtask
  task automatic expect_rx(input logic [22:0] v, input logic [2:0] s, input string n);
    int j;
    j = 0;
    do begin
      tick();
      j++;
    end while (rx_valid !== 1'h1 && j < 600);
    if (rx_valid !== 1'h1) fail(n);
    chk(n, 32'(v), 32'(rx_dlci));
    chk(n, 32'(s), 32'(rx_stat));
  endtask
  task automatic none(input int n);
    repeat (n) begin
      tick();
      chk("quiet link", 32'h0, 32'(rx_valid));
    end
  endtask
  initial begin
    repeat (4) @(posedge core_clk_in);
    rstn_in <= 1'h1;
    rd(REG_CTRL, 32'h1, "ctrl reset");
    rd(8'h08, 32'h0, "unmapped");
    wr(8'h08, 32'hFFFFFFFF);
    pulse(0, MON - 1);
    rd(REG_STATUS, 32'h0, "status early");
    pulse(0, 1);
    pulse(2, MON);
    rd(REG_STATUS, 32'h3, "status up");
    for (f = 0; f < 3; f++) begin
      @(posedge core_clk_in);
      len4 <= (f < 2);
      dc <= (f == 1);
      wr(REG_CTRL, {30'h0, f == 1, f < 2});
      d = 23'($random(seed)) & msk(f == 0 ? 23 : f == 1 ? 17 : 10);
      wr(pvc(f), word(1'h1, 1'h1, d));
      expect_rx(d, 3'h5, "add");
      send(d, 3'h1);
      chk("user active", 32'h1, 32'(act[f]));
      rd(pvc(f), word(1'h1, 1'h1, d) | 32'h3C000000, "pvc word");
      none(250);
      wr(pvc(f), word(1'h0, 1'h1, d));
      expect_rx(d, 3'h2, "delete");
      tick();
      chk("present", 32'h0, 32'(pres[f]));
    end
    d = 23'($random(seed)) & msk(10);
    wr(pvc(5), word(1'h1, 1'h1, d));
    expect_rx(d, 3'h5, "add");
    send(d, 3'h1);
    send(d, 3'h0);
    chk("user active", 32'h0, 32'(act[5]));
    none(40);
    rd(pvc(5), word(1'h1, 1'h1, d) | 32'h28000000, "pvc word");
    send(d, 3'h1);
    @(posedge core_clk_in);
    svc <= 1'h1;
    wr(pvc(5), word(1'h1, 1'h0, d));
    none(30);
    @(posedge core_clk_in);
    svc <= 1'h0;
    expect_rx(d, 3'h0, "segment down");
    wr(pvc(5), word(1'h1, 1'h1, d));
    expect_rx(d, 3'h1, "segment up");
    pulse(3, ERR);
    expect_rx(d, 3'h0, "user down");
    rd(REG_STATUS, 32'h1, "status");
    pulse(2, MON);
    expect_rx(d, 3'h1, "user up");
    pulse(1, ERR);
    tick();
    chk("user active", 32'h0, 32'(act));
    rd(REG_STATUS, 32'h2, "status");
    pulse(0, MON - 1);
    pulse(1, 1);
    pulse(0, MON - 1);
    tick();
    chk("user active", 32'h0, 32'(act[5]));
    pulse(0, 1);
    tick();
    chk("user active", 32'h1, 32'(act[5]));
    send(d, 3'h5);
    expect_rx(d, 3'h1, "new reply");
    chk("new count", 32'h1, 32'(news));
    send(d, 3'h2);
    chk("present", 32'h1, 32'(pres[5]));
    chk("user active", 32'h0, 32'(act[5]));
    finish_test();
  end
  always @(posedge core_clk_in) begin
    #1;
    if (user_new === 1'h1) begin
      news++;
      chk("new index", 32'h5, 32'(new_idx));
    end
  end
endmodule
`default_nettype wire
